/* core/timer_ch2_control.sv */
// Channel 2 timer control: counter, clear select, flags and AXI4-Lite registers
// How it works
// - Sync bit off: channel 2 runs alone
// - Mode bit selects normal or phase counting
// - Level bit drives second channel 2 pin
// - Flags set by hardware, cleared writing 0
// - Select 00 no clear, 01 clears on A
// - Select 10 clears on compare/capture B
// - Select 11 clears with synchronised channels
`timescale 1ns/1ps
`default_nettype none
module timer_ch2_control (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [timer_ctrl_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [timer_ctrl_pkg::DATA_W-1:0] wdata,
    input wire logic [timer_ctrl_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [timer_ctrl_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [timer_ctrl_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic phaseInA,
    input wire logic phaseInB,
    input wire logic captureA,
    input wire logic captureB,
    input wire logic syncClearIn,
    input wire logic syncPresetIn,
    input wire logic [timer_ctrl_pkg::COUNT_W-1:0] syncPresetValue,
    output logic ch2PinB,
    output logic [timer_ctrl_pkg::COUNT_W-1:0] ch2CountValue,
    output logic syncClearOut
);
    import timer_ctrl_pkg::*;

    typedef struct packed {
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [1:0] rResp;
        logic [DATA_W-1:0] rData;
        logic [ADDR_W-1:0] awAddr;
        logic [DATA_W-1:0] wData;
        logic [STRB_W-1:0] wStrb;
        ctrl_type ctrl;
        flags_type flags;
        logic [COUNT_W-1:0] generalRegA;
        logic [COUNT_W-1:0] generalRegB;
        logic [COUNT_W-1:0] count;
        logic pinB;
        logic syncClearOut;
    } state_type;

    state_type stateReg;
    state_type stateNext;

    logic stepUp;
    logic stepDown;
    logic clearNow;
    logic eventA;
    logic eventB;
    logic awFire;
    logic wFire;
    logic doWrite;
    logic arFire;
    logic [ADDR_W-1:0] writeAddr;
    logic [DATA_W-1:0] writeData;
    logic [STRB_W-1:0] writeStrb;
    logic ctrlWrite;
    logic statusWrite;
    logic countWrite;
    logic presetNow;
    logic countUp;
    logic countDown;

    // Merge a write into an old word, lane by lane
    function automatic logic [DATA_W-1:0] mergeBytes(
        input logic [DATA_W-1:0] oldWord,
        input logic [DATA_W-1:0] newWord,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] merged;
        merged = oldWord;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                merged[i*8 +: 8] = newWord[i*8 +: 8];
            end
        end
        return merged;
    endfunction : mergeBytes

    // True for the five mapped offsets
    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        return (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET) ||
            (addr == GEN_A_OFFSET) || (addr == GEN_B_OFFSET) || (addr == COUNT_OFFSET);
    endfunction : isMapped

    phase_step_decoder phase_step_decoder_inst (
        .clk(clk),
        .rst_b(rst_b),
        .phaseA(phaseInA),
        .phaseB(phaseInB),
        .stepUp(stepUp),
        .stepDown(stepDown)
    );

    count_clear_select count_clear_select_inst (
        .clearSelect(stateReg.ctrl.clearSelect),
        .syncEnable(stateReg.ctrl.syncEnable),
        .eventA(eventA),
        .eventB(eventB),
        .syncClearIn(syncClearIn),
        .clearNow(clearNow)
    );

    // Bus handshakes; address and data may come in either order
    assign awFire = awvalid & stateReg.awReady;
    assign wFire = wvalid & stateReg.wReady;
    assign arFire = arvalid & stateReg.arReady;
    assign writeAddr = awFire ? awaddr : stateReg.awAddr;
    assign writeData = wFire ? wdata : stateReg.wData;
    assign writeStrb = wFire ? wstrb : stateReg.wStrb;
    assign doWrite = (awFire | ~stateReg.awReady) & (wFire | ~stateReg.wReady) &
        ~stateReg.bValid;
    assign ctrlWrite = doWrite & (writeAddr == CTRL_OFFSET);
    assign statusWrite = doWrite & (writeAddr == STATUS_OFFSET);
    assign countWrite = doWrite & (writeAddr == COUNT_OFFSET);

    // Compare match or capture events; capture pulses come from pin logic
    assign eventA = (stateReg.ctrl.run & (stateReg.count == stateReg.generalRegA)) | captureA;
    assign eventB = (stateReg.ctrl.run & (stateReg.count == stateReg.generalRegB)) | captureB;

    // Outside preset only acts on a synchronised channel
    assign presetNow = stateReg.ctrl.syncEnable & syncPresetIn;
    assign countUp = stateReg.ctrl.run & (stateReg.ctrl.phaseMode ? stepUp : 1'b1);
    assign countDown = stateReg.ctrl.run & stateReg.ctrl.phaseMode & stepDown;

    // Next state of bus, registers and counter
    always_comb begin
        stateNext = stateReg;
        stateNext.syncClearOut = 1'b0;
        if (awFire) begin
            stateNext.awAddr = awaddr;
            stateNext.awReady = 1'b0;
        end
        if (wFire) begin
            stateNext.wData = wdata;
            stateNext.wStrb = wstrb;
            stateNext.wReady = 1'b0;
        end
        if (doWrite) begin
            stateNext.bValid = 1'b1;
            stateNext.bResp = isMapped(writeAddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (stateReg.bValid & bready) begin
            stateNext.bValid = 1'b0;
            stateNext.awReady = 1'b1;
            stateNext.wReady = 1'b1;
        end
        if (ctrlWrite) begin
            stateNext.ctrl = ctrl_type'(mergeBytes(DATA_W'(stateReg.ctrl), writeData,
                writeStrb));
        end
        if (doWrite & (writeAddr == GEN_A_OFFSET)) begin
            stateNext.generalRegA = COUNT_W'(mergeBytes(DATA_W'(stateReg.generalRegA),
                writeData, writeStrb));
        end
        if (doWrite & (writeAddr == GEN_B_OFFSET)) begin
            stateNext.generalRegB = COUNT_W'(mergeBytes(DATA_W'(stateReg.generalRegB),
                writeData, writeStrb));
        end
        // Captures overwrite software writes to the same register
        if (captureA) begin
            stateNext.generalRegA = stateReg.count;
        end
        if (captureB) begin
            stateNext.generalRegB = stateReg.count;
        end
        // Zero bits clear, one bits leave alone, events win over clears
        if (statusWrite & writeStrb[0]) begin
            stateNext.flags = stateReg.flags & flags_type'(writeData[FLAGS_W-1:0]);
        end
        stateNext.flags.matchA = stateNext.flags.matchA | eventA;
        stateNext.flags.matchB = stateNext.flags.matchB | eventB;
        // Counter priority: software write, sync preset, clear, step
        if (countWrite) begin
            stateNext.count = COUNT_W'(mergeBytes(DATA_W'(stateReg.count), writeData,
                writeStrb));
        end else if (presetNow) begin
            stateNext.count = syncPresetValue;
        end else if (clearNow) begin
            stateNext.count = COUNT_RESET;
        end else if (countUp) begin
            stateNext.count = stateReg.count + 16'h0001;
            if (stateReg.count == COUNT_MAX) begin
                stateNext.flags.overflow = 1'b1;
            end
        end else if (countDown) begin
            stateNext.count = stateReg.count - 16'h0001;
        end
        // Tell synchronised partners that this channel cleared itself
        if (stateReg.ctrl.syncEnable & clearNow &
            (stateReg.ctrl.clearSelect != CLEAR_SYNC)) begin
            stateNext.syncClearOut = 1'b1;
        end
        stateNext.pinB = stateNext.ctrl.pinBLevel;
        if (arFire) begin
            stateNext.arReady = 1'b0;
            stateNext.rValid = 1'b1;
            stateNext.rResp = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                CTRL_OFFSET: stateNext.rData = DATA_W'(stateReg.ctrl);
                STATUS_OFFSET: stateNext.rData = DATA_W'(stateReg.flags);
                GEN_A_OFFSET: stateNext.rData = DATA_W'(stateReg.generalRegA);
                GEN_B_OFFSET: stateNext.rData = DATA_W'(stateReg.generalRegB);
                COUNT_OFFSET: stateNext.rData = DATA_W'(stateReg.count);
                default: stateNext.rData = '0;
            endcase
        end
        if (stateReg.rValid & rready) begin
            stateNext.rValid = 1'b0;
            stateNext.arReady = 1'b1;
        end
    end

    // State registers; readies come up straight out of reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stateReg <= '0;
            stateReg.awReady <= 1'b1;
            stateReg.wReady <= 1'b1;
            stateReg.arReady <= 1'b1;
            stateReg.ctrl <= CTRL_RESET;
            stateReg.flags <= FLAGS_RESET;
            stateReg.generalRegA <= GENERAL_REG_RESET;
            stateReg.generalRegB <= GENERAL_REG_RESET;
            stateReg.count <= COUNT_RESET;
        end else begin
            stateReg <= stateNext;
        end
    end

    // Outputs all come from the state register
    assign awready = stateReg.awReady;
    assign wready = stateReg.wReady;
    assign bvalid = stateReg.bValid;
    assign bresp = stateReg.bResp;
    assign arready = stateReg.arReady;
    assign rvalid = stateReg.rValid;
    assign rresp = stateReg.rResp;
    assign rdata = stateReg.rData;
    assign ch2PinB = stateReg.pinB;
    assign ch2CountValue = stateReg.count;
    assign syncClearOut = stateReg.syncClearOut;

    // Checks on the counter, pin and flags
    indep_count_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!stateReg.ctrl.syncEnable && (syncPresetIn || syncClearIn) && !countWrite &&
        stateReg.ctrl.run && !stateReg.ctrl.phaseMode &&
        stateReg.ctrl.clearSelect == CLEAR_SYNC)
        |=> (stateReg.count == $past(stateReg.count) + 16'h0001))
        else $error("unsynchronised counter followed outside preset or clear");

    phase_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (stateReg.ctrl.phaseMode && !stepUp && !stepDown && !countWrite &&
        !presetNow && !clearNow)
        |=> $stable(stateReg.count))
        else $error("phase mode counter moved without a step");

    pin_level_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (ch2PinB == stateReg.ctrl.pinBLevel))
        else $error("pin b level differs from control bit");

    flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
        (stateReg.flags.matchA && !statusWrite)
        |=> stateReg.flags.matchA)
        else $error("match a flag dropped without a clearing write");

    flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        eventB |=> stateReg.flags.matchB)
        else $error("match b event did not set its flag");

    clear_by_a_a: assert property (@(posedge clk) disable iff (!rst_b)
        (stateReg.ctrl.clearSelect == CLEAR_BY_A && eventA && !countWrite && !presetNow)
        |=> (stateReg.count == COUNT_RESET))
        else $error("event a did not clear the counter");

    clear_by_b_a: assert property (@(posedge clk) disable iff (!rst_b)
        (stateReg.ctrl.clearSelect == CLEAR_BY_B && eventB && !countWrite && !presetNow)
        |=> (stateReg.count == COUNT_RESET))
        else $error("event b did not clear the counter");

    sync_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (stateReg.ctrl.clearSelect == CLEAR_SYNC && stateReg.ctrl.syncEnable &&
        syncClearIn && !countWrite && !presetNow)
        |=> (stateReg.count == COUNT_RESET))
        else $error("synchronous clear missed");

    no_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (stateReg.ctrl.clearSelect == CLEAR_NONE && stateReg.ctrl.run &&
        !stateReg.ctrl.phaseMode && !countWrite && !presetNow)
        |=> (stateReg.count == $past(stateReg.count) + 16'h0001))
        else $error("counter cleared or stalled with clearing disabled");

endmodule : timer_ch2_control
`default_nettype wire

/* core/timer_ctrl_pkg.sv */
// Shared constants and types for the channel 2 timer control block
package timer_ctrl_pkg;

    // Bus geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned STRB_W = DATA_W / 8;
    localparam int unsigned COUNT_W = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] GEN_A_OFFSET = 8'h08;
    localparam logic [ADDR_W-1:0] GEN_B_OFFSET = 8'h0c;
    localparam logic [ADDR_W-1:0] COUNT_OFFSET = 8'h10;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Counter clear source, two bits: hi then lo
    typedef enum logic [1:0] {
        CLEAR_NONE = 2'b00,
        CLEAR_BY_A = 2'b01,
        CLEAR_BY_B = 2'b10,
        CLEAR_SYNC = 2'b11
    } clear_select_type;

    // Control register layout, bit 0 is syncEnable
    typedef struct packed {
        logic run;
        clear_select_type clearSelect;
        logic pinBLevel;
        logic phaseMode;
        logic syncEnable;
    } ctrl_type;

    // Status flags, bit 0 is matchA
    typedef struct packed {
        logic overflow;
        logic matchB;
        logic matchA;
    } flags_type;

    // Field widths and reset values
    localparam int unsigned CTRL_W = $bits(ctrl_type);
    localparam int unsigned FLAGS_W = $bits(flags_type);
    localparam ctrl_type CTRL_RESET = 6'h00;
    localparam flags_type FLAGS_RESET = 3'h0;
    localparam logic [COUNT_W-1:0] GENERAL_REG_RESET = 16'hffff;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;

endpackage : timer_ctrl_pkg

/* core/phase_step_decoder.sv */
// Two-input phase decoder giving up and down count steps
`timescale 1ns/1ps
`default_nettype none
module phase_step_decoder (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic phaseA,
    input wire logic phaseB,
    output logic stepUp,
    output logic stepDown
);
    typedef struct packed {
        logic primed;
        logic prevA;
        logic prevB;
    } decoder_state_type;

    decoder_state_type stateReg;
    decoder_state_type stateNext;

    // Primed flag stops a false step from inputs held high through reset
    always_comb begin
        stateNext = '{primed: 1'b1, prevA: phaseA, prevB: phaseB};
        stepUp = 1'b0;
        stepDown = 1'b0;
        if (stateReg.primed) begin
            case ({stateReg.prevA, stateReg.prevB, phaseA, phaseB})
                4'b0010, 4'b1011, 4'b1101, 4'b0100: stepUp = 1'b1;
                4'b1000, 4'b1110, 4'b0111, 4'b0001: stepDown = 1'b1;
                default: begin
                    stepUp = 1'b0;
                    stepDown = 1'b0;
                end
            endcase
        end
    end

    // Sampling registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end
endmodule : phase_step_decoder
`default_nettype wire

/* core/count_clear_select.sv */
// Chooses the counter clear source from the two select bits
`timescale 1ns/1ps
`default_nettype none
module count_clear_select (
    input wire timer_ctrl_pkg::clear_select_type clearSelect,
    input wire logic syncEnable,
    input wire logic eventA,
    input wire logic eventB,
    input wire logic syncClearIn,
    output logic clearNow
);
    import timer_ctrl_pkg::*;

    // Sync clear only counts when this channel is synchronised
    always_comb begin
        case (clearSelect)
            CLEAR_NONE: clearNow = 1'b0;
            CLEAR_BY_A: clearNow = eventA;
            CLEAR_BY_B: clearNow = eventB;
            CLEAR_SYNC: clearNow = syncEnable & syncClearIn;
            default: clearNow = 1'b0;
        endcase
    end
endmodule : count_clear_select
`default_nettype wire

/* testbench/multi_channel_timer_control_tb_top.sv */
// Self-checking bench for the channel 2 timer control block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, expv, gotv) begin samplesChecked++; if ((gotv) !== (expv)) begin errorCnt++; $display("Error %s expected %h seen %h", what, expv, gotv); end end
module multi_channel_timer_control_tb_top;
    import timer_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [STRB_W-1:0] wstrb = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ch2PinB, syncClearOut;
    logic [1:0] bresp, rresp;
    logic phaseInA = 1'b0, phaseInB = 1'b0, captureA = 1'b0, captureB = 1'b0;
    logic syncClearIn = 1'b0, syncPresetIn = 1'b0;
    logic [COUNT_W-1:0] syncPresetValue = '0, ch2CountValue;
    int errorCnt = 0;
    int samplesChecked = 0;

    timer_ch2_control timer_ch2_control_inst (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .phaseInA(phaseInA), .phaseInB(phaseInB), .captureA(captureA),
        .captureB(captureB), .syncClearIn(syncClearIn), .syncPresetIn(syncPresetIn),
        .syncPresetValue(syncPresetValue), .ch2PinB(ch2PinB), .ch2CountValue(ch2CountValue),
        .syncClearOut(syncClearOut));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Verdict and end of run, shared by the main sequence and the watchdog
    task automatic completeRun();
        $display("Checks %0d errors %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : completeRun

    // Handshakes judged at the falling edge, where everything sampled next is settled
    task automatic busWrite(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
            input logic [1:0] expResp);
        logic awHit, wHit, bHit;
        logic [1:0] resp;
        bHit = 1'b0;
        @(posedge clk);
        awaddr <= addr;
        wdata <= data;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !bHit; n++) begin
            @(negedge clk);
            awHit = awvalid && awready;
            wHit = wvalid && wready;
            bHit = bvalid && bready;
            resp = bresp;
            @(posedge clk);
            if (awHit) awvalid <= 1'b0;
            if (wHit) wvalid <= 1'b0;
            if (bHit) bready <= 1'b0;
        end
        `CHECK("write done", 1'b1, bHit)
        `CHECK("write response", expResp, resp)
    endtask : busWrite

    // Read one word and compare data and response
    task automatic busRead(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] expData,
            input logic [1:0] expResp, input string what);
        logic arHit, rHit;
        logic [DATA_W-1:0] data;
        logic [1:0] resp;
        rHit = 1'b0;
        @(posedge clk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !rHit; n++) begin
            @(negedge clk);
            arHit = arvalid && arready;
            rHit = rvalid && rready;
            data = rdata;
            resp = rresp;
            @(posedge clk);
            if (arHit) arvalid <= 1'b0;
            if (rHit) rready <= 1'b0;
        end
        `CHECK("read done", 1'b1, rHit)
        `CHECK(what, expData, data)
        `CHECK("read response", expResp, resp)
    endtask : busRead

    // Polls the counter; bounded so a stuck counter cannot hang the run
    task automatic waitCount(input logic [COUNT_W-1:0] target, output logic found);
        found = 1'b0;
        for (int n = 0; n < 200 && !found; n++) begin
            @(negedge clk);
            found = (ch2CountValue === target);
        end
    endtask : waitCount

    task automatic checkResetValues();
        busRead(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY, "ctrl reset");
        busRead(STATUS_OFFSET, 32'h0000_0000, RESP_OKAY, "status reset");
        busRead(GEN_A_OFFSET, 32'h0000_ffff, RESP_OKAY, "reg a reset");
        busRead(GEN_B_OFFSET, 32'h0000_ffff, RESP_OKAY, "reg b reset");
        busRead(COUNT_OFFSET, 32'h0000_0000, RESP_OKAY, "count reset");
        `CHECK("pin b reset", 1'b0, ch2PinB)
    endtask : checkResetValues

    task automatic checkPinLevel();
        busWrite(CTRL_OFFSET, 32'h0000_0004, RESP_OKAY);
        @(negedge clk);
        `CHECK("pin b high", 1'b1, ch2PinB)
        busWrite(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        @(negedge clk);
        `CHECK("pin b low", 1'b0, ch2PinB)
    endtask : checkPinLevel

    // Select 00 wraps past ffff and passes both matches; 01 and 10 clear after their match
    task automatic checkCompareClear();
        logic found;
        busWrite(GEN_A_OFFSET, 32'h0000_0005, RESP_OKAY);
        busWrite(GEN_B_OFFSET, 32'h0000_0008, RESP_OKAY);
        busWrite(COUNT_OFFSET, 32'h0000_fffc, RESP_OKAY);
        busWrite(CTRL_OFFSET, 32'h0000_0020, RESP_OKAY);
        waitCount(16'h000c, found);
        `CHECK("no clear select", 1'b1, found)
        busWrite(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        busWrite(COUNT_OFFSET, 32'h0000_0000, RESP_OKAY);
        busWrite(CTRL_OFFSET, 32'h0000_0028, RESP_OKAY);
        waitCount(16'h0005, found);
        @(negedge clk);
        `CHECK("clear on match a", 17'h1_0000, {found, ch2CountValue})
        busWrite(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        busWrite(COUNT_OFFSET, 32'h0000_0000, RESP_OKAY);
        busWrite(CTRL_OFFSET, 32'h0000_0030, RESP_OKAY);
        waitCount(16'h0008, found);
        @(negedge clk);
        `CHECK("clear on match b", 17'h1_0000, {found, ch2CountValue})
        busWrite(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
    endtask : checkCompareClear

    // Match and overflow flags are set by now; ones are ignored, zeros clear per bit
    task automatic checkFlagClear();
        busRead(STATUS_OFFSET, 32'h0000_0007, RESP_OKAY, "flags set");
        busWrite(STATUS_OFFSET, 32'h0000_0007, RESP_OKAY);
        busRead(STATUS_OFFSET, 32'h0000_0007, RESP_OKAY, "flags after ones");
        busWrite(STATUS_OFFSET, 32'h0000_0002, RESP_OKAY);
        busRead(STATUS_OFFSET, 32'h0000_0002, RESP_OKAY, "flag a cleared");
        busWrite(STATUS_OFFSET, 32'h0000_0000, RESP_OKAY);
        busRead(STATUS_OFFSET, 32'h0000_0000, RESP_OKAY, "flags cleared");
    endtask : checkFlagClear

    // Capture pulses clear the running counter on the following edge
    task automatic checkCaptureClear();
        busWrite(GEN_A_OFFSET, 32'h0000_0100, RESP_OKAY);
        busWrite(GEN_B_OFFSET, 32'h0000_0100, RESP_OKAY);
        busWrite(CTRL_OFFSET, 32'h0000_0029, RESP_OKAY);
        repeat (3) @(posedge clk);
        captureA <= 1'b1;
        @(posedge clk);
        captureA <= 1'b0;
        @(negedge clk);
        `CHECK("clear on capture a", 16'h0000, ch2CountValue)
        `CHECK("sync clear out", 1'b1, syncClearOut)
        busWrite(CTRL_OFFSET, 32'h0000_0030, RESP_OKAY);
        repeat (3) @(posedge clk);
        captureB <= 1'b1;
        @(posedge clk);
        captureB <= 1'b0;
        @(negedge clk);
        `CHECK("clear on capture b", 16'h0000, ch2CountValue)
        `CHECK("no sync clear out", 1'b0, syncClearOut)
    endtask : checkCaptureClear

    // Sync clear and preset act only while the sync bit is set
    task automatic checkSyncOps();
        logic [DATA_W-1:0] ctrlSeq [2] = '{32'h0000_0039, 32'h0000_0038};
        for (int i = 0; i < 2; i++) begin
            busWrite(CTRL_OFFSET, ctrlSeq[i], RESP_OKAY);
            repeat (3) @(posedge clk);
            syncClearIn <= 1'b1;
            @(posedge clk);
            syncClearIn <= 1'b0;
            @(negedge clk);
            `CHECK("sync clear", i == 0, ch2CountValue == 16'h0000)
        end
        busWrite(CTRL_OFFSET, 32'h0000_0001, RESP_OKAY);
        syncPresetValue <= 16'h1234;
        syncPresetIn <= 1'b1;
        @(posedge clk);
        syncPresetIn <= 1'b0;
        busWrite(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        syncPresetValue <= 16'h0abc;
        syncPresetIn <= 1'b1;
        @(posedge clk);
        syncPresetIn <= 1'b0;
        @(negedge clk);
        `CHECK("preset only when synced", 16'h1234, ch2CountValue)
    endtask : checkSyncOps

    // Phase mode: still inputs hold the count, a full cycle each way is four steps
    task automatic checkPhaseMode();
        logic [1:0] upSeq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
        busWrite(COUNT_OFFSET, 32'h0000_0010, RESP_OKAY);
        busWrite(CTRL_OFFSET, 32'h0000_0022, RESP_OKAY);
        repeat (5) @(negedge clk);
        `CHECK("phase idle", 16'h0010, ch2CountValue)
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 4; i++) begin
                @(posedge clk);
                {phaseInA, phaseInB} <= d == 0 ? upSeq[i] : {upSeq[i][0], upSeq[i][1]};
                repeat (3) @(posedge clk);
            end
            repeat (4) @(negedge clk);
            `CHECK("phase count", d == 0 ? 16'h0014 : 16'h0010, ch2CountValue)
        end
        busWrite(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
    endtask : checkPhaseMode

    task automatic checkUnmapped();
        busWrite(8'h14, 32'h0000_00ff, RESP_SLVERR);
        busRead(8'h14, 32'h0000_0000, RESP_SLVERR, "unmapped read");
    endtask : checkUnmapped

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        $display("Error watchdog expired");
        errorCnt++;
        completeRun();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        checkResetValues();
        checkPinLevel();
        checkCompareClear();
        checkFlagClear();
        checkCaptureClear();
        checkSyncOps();
        checkPhaseMode();
        checkUnmapped();
        completeRun();
    end
endmodule : multi_channel_timer_control_tb_top
`undef CHECK
`default_nettype wire
